// [uarsi_defines.svh]
// Purpose: Constants for the receive status and interrupt block
// Assumes: 10 MHz clock, one 32-bit status/control word plus irq registers
// Notes:   Offsets are byte addresses on the plain register port
`ifndef UARSI_DEFINES_SVH
`define UARSI_DEFINES_SVH
`define UARSI_OFF_STA      8'h00
`define UARSI_OFF_DATA     8'h04
`define UARSI_OFF_ISTAT    8'h08
`define UARSI_OFF_IMASK    8'h0C
`define UARSI_OFF_CFG      8'h10
`define UARSI_BIT_LVL_HI   7
`define UARSI_BIT_LVL_LO   6
`define UARSI_BIT_ADDR     5
`define UARSI_BIT_QUIET    4
`define UARSI_BIT_PARITY_ERROR_FLAG     3
`define UARSI_BIT_FRAMING_ERROR_FLAG     2
`define UARSI_BIT_OVR      1
`define UARSI_BIT_AVAIL    0
`define UARSI_LVL_ANY      2'h0
`define UARSI_LVL_HALF     2'h1
`define UARSI_LVL_3Q       2'h2
`define UARSI_DEPTH        8
`define UARSI_PTR_W        3
`define UARSI_CNT_W        4
`define UARSI_HALF_CNT     4'h4
`define UARSI_3Q_CNT       4'h6
`define UARSI_EV_RXIRQ     0
`define UARSI_EV_OVR       1
`define UARSI_EV_ERR       2
`define UARSI_EV_ADDR      3
`define UARSI_EV_W         4
`endif

// [uarsi_fill_if.sv]
// Purpose: Fill level carrier between top and level comparator
// Assumes: Count in characters
// Notes:   Comparator is pure logic
`timescale 1ns/1ps
`include "uarsi_defines.svh"
interface uarsi_fill_if;
  logic [`UARSI_CNT_W-1:0] count;
  logic [1:0]              level_sel;
  logic                    irq_level;
  modport top (output count, output level_sel, input irq_level);
  modport cmp (input count, input level_sel, output irq_level);
endinterface

// [uarsi_level_cmp.sv]
// Purpose: Receive interrupt level decision from fill count
// Assumes: Depth 8, code 11 reserved and never raises
// Notes:   Combinational only
`timescale 1ns/1ps
`include "uarsi_defines.svh"
module uarsi_level_cmp (
  // Fill carrier
  uarsi_fill_if.cmp fill
);
  // Threshold by level code
  always_comb begin
    case (fill.level_sel)
      `UARSI_LVL_ANY:  fill.irq_level = (fill.count != 4'h0);
      `UARSI_LVL_HALF: fill.irq_level = (fill.count >= `UARSI_HALF_CNT);
      `UARSI_LVL_3Q:   fill.irq_level = (fill.count >= `UARSI_3Q_CNT);
      default:         fill.irq_level = 1'b0;
    endcase
  end
endmodule

// [uarsi_pkg.sv]
// Purpose: Types for the receive status and interrupt block
// Assumes: Included constants header
// Notes:   One packed entry per buffered character
package uarsi_pkg;
  typedef struct packed {
    logic [8:0] data;
    logic       parity_error_flag;
    logic       framing_error_flag;
  } uarsi_char_t;
  typedef enum logic [1:0] {
    UARSI_IDLE = 2'b01,
    UARSI_BUSY = 2'b10
  } uarsi_rx_state_t;
endpackage

// [uarsi_top.sv]
// Purpose: Receive status, buffer, overrun and interrupt level logic
// Assumes: Shift register side delivers start pulse and done pulse with status
// Notes:   Registers on a plain port, read data one cycle after read strobe
`timescale 1ns/1ps
`include "uarsi_defines.svh"
module uarsi_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Shift register side
  input  wire logic        rx_start,
  input  wire logic        rx_done,
  input  wire logic [8:0]  rx_char,
  input  wire logic        rx_parity_error_flag,
  input  wire logic        rx_framing_error_flag,
  input  wire logic        nine_bit_mode,
  // Status outputs
  output logic             shift_flush,
  output logic             rx_irq_flag,
  output logic             irq
);
  typedef struct packed {
    uarsi_pkg::uarsi_char_t [`UARSI_DEPTH-1:0] mem;
    logic [`UARSI_PTR_W-1:0]  wp;
    logic [`UARSI_PTR_W-1:0]  rp;
    logic [`UARSI_CNT_W-1:0]  cnt;
    uarsi_pkg::uarsi_rx_state_t st;
    logic [1:0]               lvl;
    logic                     addr_mode;
    logic                     ovr;
    logic                     flush;
    logic [`UARSI_EV_W-1:0]   istat;
    logic [`UARSI_EV_W-1:0]   imask;
    logic [31:0]              rdata;
    logic                     irqf;
    logic                     irq;
  } uarsi_state_t;

  uarsi_state_t s_r;
  uarsi_state_t s_nxt;
  uarsi_fill_if fill ();

  // Level comparator
  assign fill.count     = s_r.cnt;
  assign fill.level_sel = s_r.lvl;
  uarsi_level_cmp u_cmp (
    .fill (fill)
  );

  // Write decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic                   is_addr;
  logic                   push;
  logic                   pop;
  logic                   ovr_clr;
  uarsi_pkg::uarsi_char_t head;
  logic [31:0]            sta_word;
  logic [`UARSI_EV_W-1:0] ev;

  // Status word assembly
  always_comb begin
    head     = s_r.mem[s_r.rp];
    sta_word = 32'h0;
    sta_word[`UARSI_BIT_LVL_HI:`UARSI_BIT_LVL_LO] = s_r.lvl;
    sta_word[`UARSI_BIT_ADDR]  = s_r.addr_mode;
    sta_word[`UARSI_BIT_QUIET] = (s_r.st == uarsi_pkg::UARSI_IDLE);
    sta_word[`UARSI_BIT_PARITY_ERROR_FLAG]  = (s_r.cnt != 4'h0) && head.parity_error_flag;
    sta_word[`UARSI_BIT_FRAMING_ERROR_FLAG]  = (s_r.cnt != 4'h0) && head.framing_error_flag;
    sta_word[`UARSI_BIT_OVR]   = s_r.ovr;
    sta_word[`UARSI_BIT_AVAIL] = (s_r.cnt != 4'h0);
  end

  // Next state
  always_comb begin
    s_nxt   = s_r;
    ovr_clr = reg_wr && hit(reg_addr, `UARSI_OFF_STA) && s_r.ovr
              && !reg_wdata[`UARSI_BIT_OVR];
    is_addr = s_r.addr_mode && nine_bit_mode && rx_char[8];
    pop     = reg_rd && hit(reg_addr, `UARSI_OFF_DATA) && (s_r.cnt != 4'h0);
    push    = rx_done && !s_r.ovr && !ovr_clr
              && ((s_r.cnt != 4'h8) || pop);
    ev      = '0;
    s_nxt.flush = 1'b0;
    // Receiver activity
    case (s_r.st)
      uarsi_pkg::UARSI_IDLE: if (rx_start) s_nxt.st = uarsi_pkg::UARSI_BUSY;
      uarsi_pkg::UARSI_BUSY: if (rx_done) s_nxt.st = uarsi_pkg::UARSI_IDLE;
      default:               s_nxt.st = uarsi_pkg::UARSI_IDLE;
    endcase
    // Buffer
    if (push) begin
      s_nxt.mem[s_r.wp] = '{data: rx_char, parity_error_flag: rx_parity_error_flag, framing_error_flag: rx_framing_error_flag};
      s_nxt.wp = s_r.wp + 3'h1;
    end
    if (pop) s_nxt.rp = s_r.rp + 3'h1;
    s_nxt.cnt = s_r.cnt + {3'h0, push} - {3'h0, pop};
    if (rx_done && (rx_parity_error_flag || rx_framing_error_flag)) ev[`UARSI_EV_ERR] = 1'b1;
    if (rx_done && is_addr && !s_r.ovr) ev[`UARSI_EV_ADDR] = 1'b1;
    // Overrun
    if (ovr_clr) begin
      s_nxt.ovr   = 1'b0;
      s_nxt.wp    = 3'h0;
      s_nxt.rp    = 3'h0;
      s_nxt.cnt   = 4'h0;
      s_nxt.st    = uarsi_pkg::UARSI_IDLE;
      s_nxt.flush = 1'b1;
    end
    if (rx_done && !s_r.ovr && !ovr_clr && (s_r.cnt == 4'h8) && !pop) begin
      s_nxt.ovr = 1'b1;
      ev[`UARSI_EV_OVR] = 1'b1;
    end
    // Control writes
    if (reg_wr && hit(reg_addr, `UARSI_OFF_STA)) begin
      s_nxt.lvl       = reg_wdata[`UARSI_BIT_LVL_HI:`UARSI_BIT_LVL_LO];
      s_nxt.addr_mode = reg_wdata[`UARSI_BIT_ADDR];
    end
    if (reg_wr && hit(reg_addr, `UARSI_OFF_IMASK))
      s_nxt.imask = reg_wdata[`UARSI_EV_W-1:0];
    ev[`UARSI_EV_RXIRQ] = fill.irq_level;
    // Sticky status, set wins over clear
    if (reg_wr && hit(reg_addr, `UARSI_OFF_ISTAT))
      s_nxt.istat = s_r.istat & ~reg_wdata[`UARSI_EV_W-1:0];
    s_nxt.istat = s_nxt.istat | ev;
    // Read data
    s_nxt.rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `UARSI_OFF_STA:   s_nxt.rdata = sta_word;
        `UARSI_OFF_DATA:  s_nxt.rdata = {23'h0, head.data};
        `UARSI_OFF_ISTAT: s_nxt.rdata = {28'h0, s_r.istat};
        `UARSI_OFF_IMASK: s_nxt.rdata = {28'h0, s_r.imask};
        default:          s_nxt.rdata = 32'h0;
      endcase
    end
    s_nxt.irqf = fill.irq_level;
    s_nxt.irq  = |(s_nxt.istat & s_nxt.imask);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r     <= '0;
      s_r.st  <= uarsi_pkg::UARSI_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign reg_rdata   = s_r.rdata;
  assign shift_flush = s_r.flush;
  assign rx_irq_flag = s_r.irqf;
  assign irq         = s_r.irq;

  // Checks
  ovr_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ovr && !(reg_wr && reg_addr == `UARSI_OFF_STA && !reg_wdata[1]) |=> s_r.ovr)
    else $error("overrun cleared without software");
  ovr_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && !s_r.ovr && s_r.cnt == 4'h8 && !pop && !ovr_clr |=> s_r.ovr)
    else $error("overflow did not set overrun");
  ovr_flush_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovr_clr |=> s_r.cnt == 4'h0 && shift_flush ##1 !shift_flush)
    else $error("overrun clear did not empty buffer");
  ovr_discard_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ovr && !ovr_clr && !pop |=> s_r.cnt == $past(s_r.cnt))
    else $error("character stored during overrun");
  avail_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `UARSI_OFF_STA |=> reg_rdata[0] == ($past(s_r.cnt) != 4'h0))
    else $error("data available wrong");
  quiet_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_start && s_r.st == uarsi_pkg::UARSI_IDLE && !ovr_clr |=> !sta_word[4])
    else $error("quiet flag high while receiving");
  err_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.cnt == 4'h0 |-> !sta_word[3] && !sta_word[2])
    else $error("error flag with empty buffer");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.lvl == 2'h2 && s_r.cnt >= 4'h6 |=> rx_irq_flag)
    else $error("three-quarter level missed");
  half_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.lvl == 2'h1 && s_r.cnt < 4'h4 |=> !rx_irq_flag)
    else $error("half level raised early");
  addr_det_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && !nine_bit_mode |=> !s_r.istat[3] || $past(s_r.istat[3]))
    else $error("address seen outside 9-bit mode");
  framing_error_flag_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.cnt != 4'h0 && head.framing_error_flag |-> sta_word[2])
    else $error("framing flag missing");
  // Remaining level codes
  code_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.lvl == 2'h3 |=> !rx_irq_flag)
    else $error("reserved level code raised flag");
  any_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.lvl == 2'h0 && s_r.cnt != 4'h0 |=> rx_irq_flag)
    else $error("not-empty level missed");

  // Address character event in nine-bit mode
  addr_evt_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && nine_bit_mode && s_r.addr_mode && rx_char[8] && !s_r.ovr |=> s_r.istat[3])
    else $error("address character not flagged");

  // Receiver returns to quiet when a character completes
  quiet_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.st == uarsi_pkg::UARSI_BUSY && rx_done |=> sta_word[4])
    else $error("quiet flag low after character end");

  // Error events become sticky status
  err_evt_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && (rx_parity_error_flag || rx_framing_error_flag) |=> s_r.istat[2])
    else $error("character error not recorded");

  // Overrun event in the sticky status
  ovr_evt_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_done && !s_r.ovr && !ovr_clr && s_r.cnt == 4'h8 && !pop |=> s_r.istat[1])
    else $error("overrun event not recorded");
  ovr_istat_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.istat[1] && !(reg_wr && reg_addr == `UARSI_OFF_ISTAT && reg_wdata[1])
    |=> s_r.istat[1])
    else $error("sticky overrun status lost");

  // Flush strobe only follows an overrun clear
  flush_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ovr_clr |=> !shift_flush)
    else $error("flush without overrun clear");

  // Buffer count bookkeeping
  cnt_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |-> s_r.cnt <= 4'h8)
    else $error("buffer count beyond depth");
  pop_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    pop && !rx_done && !ovr_clr |=> s_r.cnt == $past(s_r.cnt) - 4'h1)
    else $error("data read did not pop");
  pop_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `UARSI_OFF_DATA && s_r.cnt == 4'h0 && !rx_done |=> s_r.cnt == 4'h0)
    else $error("pop of empty buffer counted");

  // Read port answers only the cycle after a read strobe
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read strobe");

  // Interrupt output follows masked sticky status
  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |-> irq == |(s_r.istat & s_r.imask))
    else $error("interrupt output disagrees with status");

  // Main scenarios
  full_c: cover property (@(posedge clk) s_r.cnt == 4'h8);
  ovr_c: cover property (@(posedge clk) ovr_clr);
  irq_c: cover property (@(posedge clk) irq);
  addr_c: cover property (@(posedge clk) rx_done && is_addr);
  busy_c: cover property (@(posedge clk) s_r.st == uarsi_pkg::UARSI_BUSY);
endmodule

// [uarsi_top_bench.sv]
// Purpose: Self-checking bench for the receive status and interrupt block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Fill levels are swept with every level code at every count from 1 to 8
`timescale 1ns/1ps
`include "uarsi_defines.svh"
module uarsi_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        nine_bit_mode = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_start, rx_done, rx_parity_error_flag, rx_framing_error_flag, shift_flush, rx_irq_flag, irq;
  logic [8:0]  rx_char;
  int          miscompares = 0;
  int          num_checks = 0;
  int          flushes = 0;
  logic        e;
  // Clock at 100 ns period
  always #50 clk = ~clk;
  uarsi_tx_model uarsi_tx_model_i (.clk(clk), .rx_start(rx_start), .rx_done(rx_done),
    .rx_char(rx_char), .rx_parity_error_flag(rx_parity_error_flag), .rx_framing_error_flag(rx_framing_error_flag));
  uarsi_top uarsi_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_start(rx_start), .rx_done(rx_done), .rx_char(rx_char), .rx_parity_error_flag(rx_parity_error_flag),
    .rx_framing_error_flag(rx_framing_error_flag), .nine_bit_mode(nine_bit_mode), .shift_flush(shift_flush),
    .rx_irq_flag(rx_irq_flag), .irq(irq));
  // Count flush pulses
  always @(posedge clk) if (shift_flush === 1'b1) flushes++;
  // Verdict and end of run
  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // One-cycle read, masked compare in the answer cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask
  // Settle one cycle, then compare a port level
  task automatic lvl(input logic got_sel, input logic exp);
    @(posedge clk);
    #1 chk({31'h0, got_sel ? irq : rx_irq_flag}, {31'h0, exp});
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`UARSI_OFF_STA, 32'hFF, 32'h10);
    uarsi_tx_model_i.begin_frame();
    rd(`UARSI_OFF_STA, 32'h10, 32'h00);
    uarsi_tx_model_i.end_frame(9'h0A5, 1'b1, 1'b0, 2);
    rd(`UARSI_OFF_STA, 32'h1D, 32'h19);
    rd(`UARSI_OFF_DATA, 32'h1FF, 32'h0A5);
    rd(`UARSI_OFF_STA, 32'h0D, 32'h00);
    uarsi_tx_model_i.send(9'h05A, 1'b0, 1'b1, 0);
    rd(`UARSI_OFF_STA, 32'h0D, 32'h05);
    rd(`UARSI_OFF_DATA, 32'h1FF, 32'h05A);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    // Fill to depth, trying every level code at each count
    for (int n = 1; n <= `UARSI_DEPTH; n++) begin
      uarsi_tx_model_i.send(9'(n), 1'b0, 1'b0, n % 3);
      for (int c = 0; c < 4; c++) begin
        e = (c == 0) ? 1'b1 : (c == 1) ? (n >= `UARSI_HALF_CNT) :
            (c == 2) ? (n >= `UARSI_3Q_CNT) : 1'b0;
        wr(`UARSI_OFF_STA, 32'(c) << 6);
        lvl(1'b0, e);
      end
    end
    uarsi_tx_model_i.send(9'h0EE, 1'b0, 1'b0, 1);
    rd(`UARSI_OFF_STA, 32'h03, 32'h03);
    rd(`UARSI_OFF_DATA, 32'h1FF, 32'h001);
    uarsi_tx_model_i.send(9'h0DD, 1'b0, 1'b0, 0);
    rd(`UARSI_OFF_DATA, 32'h1FF, 32'h002);
    rd(`UARSI_OFF_STA, 32'h03, 32'h03);
    rd(`UARSI_OFF_ISTAT, 32'h02, 32'h02);
    lvl(1'b1, 1'b0);
    wr(`UARSI_OFF_IMASK, 32'h2);
    lvl(1'b1, 1'b1);
    wr(`UARSI_OFF_STA, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(flushes), 32'h1);
    rd(`UARSI_OFF_STA, 32'h03, 32'h00);
    wr(`UARSI_OFF_ISTAT, 32'h2);
    lvl(1'b1, 1'b0);
    // Address characters only count in nine-bit mode
    wr(`UARSI_OFF_ISTAT, 32'hF);
    wr(`UARSI_OFF_STA, 32'h20);
    uarsi_tx_model_i.send(9'h155, 1'b0, 1'b0, 1);
    rd(`UARSI_OFF_ISTAT, 32'h08, 32'h00);
    rd(`UARSI_OFF_DATA, 32'h1FF, 32'h155);
    nine_bit_mode <= 1'b1;
    uarsi_tx_model_i.send(9'h155, 1'b0, 1'b0, 1);
    rd(`UARSI_OFF_ISTAT, 32'h08, 32'h08);
    close_out();
  end
endmodule

// [uarsi_tx_model.sv]
// Purpose: Far-end transmitter stand-in feeding the receive status block
// Assumes: Start pulse at the start bit, done pulse with the character
// Notes:   Character lines show the inverse of the last value between frames
`timescale 1ns/1ps
module uarsi_tx_model (
  // Clock
  input  wire logic       clk,
  // Shift register handshake
  output logic            rx_start,
  output logic            rx_done,
  output logic      [8:0] rx_char,
  output logic            rx_parity_error_flag,
  output logic            rx_framing_error_flag
);
  // Quiet lines at time zero
  initial begin
    rx_start = 1'b0;
    rx_done  = 1'b0;
    rx_char  = 9'h1AA;
    rx_parity_error_flag  = 1'b1;
    rx_framing_error_flag  = 1'b1;
  end
  // Start bit seen
  task automatic begin_frame();
    @(posedge clk);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
  endtask
  // Character complete after a gap, then stale values are scrambled
  task automatic end_frame(input logic [8:0] ch, input logic pe, input logic fe,
                           input int gap);
    repeat (gap) @(posedge clk);
    rx_done <= 1'b1;
    rx_char <= ch;
    rx_parity_error_flag <= pe;
    rx_framing_error_flag <= fe;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_char <= ~ch;
    rx_parity_error_flag <= ~pe;
    rx_framing_error_flag <= ~fe;
  endtask
  // Whole character
  task automatic send(input logic [8:0] ch, input logic pe, input logic fe, input int gap);
    begin_frame();
    end_frame(ch, pe, fe, gap);
  endtask
endmodule
